//--- iru_cpu_model.sv
`timescale 1ns/1ps
// ---------------------------------------------
// CPU core that accepts pending requests
// ---------------------------------------------
module iru_cpu_model (
  input  wire logic       clock_i,
  input  wire logic       reset_n_i,
  input  wire logic       accept_en_i,
  input  wire logic [3:0] delay_i,
  input  wire logic       irq_i,
  input  wire logic       nmi_i,
  input  wire logic [5:0] int_id_i,
  output logic            cpu_ack_o,
  output logic      [5:0] cpu_ack_id_o,
  output logic      [5:0] last_id_o
);
  logic [3:0] pend_q;
  logic [3:0] hold_q;
  // Hold-off lets the cleared flag reach irq_o before the next look
  always @(posedge clock_i) begin
    cpu_ack_o <= 1'b0;
    cpu_ack_id_o <= ~cpu_ack_id_o;
    if (!reset_n_i) begin
      pend_q <= 4'h0;
      hold_q <= 4'h0;
      cpu_ack_id_o <= 6'h00;
      last_id_o <= 6'h00;
    end else if (hold_q != 4'h0) begin
      hold_q <= hold_q - 4'h1;
    end else if (accept_en_i && (irq_i || nmi_i)) begin
      pend_q <= pend_q + 4'h1;
      if (pend_q >= delay_i) begin
        cpu_ack_o <= 1'b1;
        cpu_ack_id_o <= int_id_i;
        last_id_o <= int_id_i;
        pend_q <= 4'h0;
        hold_q <= 4'h4;
      end
    end
  end
endmodule

//--- iru_pkg.sv
// Summary of operation
// R1: Twenty-six hardware sources, nine external and seventeen internal, plus a software interrupt.
// R2: Watchdog and external NMI are non-maskable and ignore the master enable.
// R3: Twenty-four maskable sources, sixteen internal and eight pins, each with an enable.
// R4: Software interrupt carries a vector number with up to 64 values.
// R5: Each pin has a software-chosen trigger edge and an optional sampling select.
// R6: The selected edge on pin n raises port request n.
// R7: Accepting a maskable request clears master enable; per-source enables stay unchanged.
// R8: Port enable bits 0 to 7 enable pins 0 to 7; one enables, reset zero.
// R9: Serial/ADC enable: serial0 bit0, serial1 bit1, ADC bit2, I2C slave bit6, master bit7.
// R10: Timer/voice enable: timer0 bit0, timer1 bit1, voice0 bit4, speaker short bit5.
// R11: UART enable register holds only the UART 0 enable at bit 0, reset zero.
// R12: Upper timer enable register holds timer 2 enable at bit 4.
// R13: Seven enable and eight request registers, consecutive, eight bits, read/write, reset 00H.
// R14: Edge mode 00 off, 01 falling, 10 rising, 11 both; high bit separate.
// R15: Sampled pins use the 16 kHz tick, which halts in stop mode.
// R16: Request flags set regardless of enables; CPU signalled only with source and master enable.
// R17: Acceptance clears that request flag; software writing one triggers the interrupt.
// R18: Unused enable bits read zero and ignore writes.
package iru_pkg;

  // -----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // -----------------------------------------------------------------
  localparam logic [15:0] IRU_IDX_EN1   = 16'hF011;
  localparam logic [15:0] IRU_IDX_EN2   = 16'hF012;
  localparam logic [15:0] IRU_IDX_EN3   = 16'hF013;
  localparam logic [15:0] IRU_IDX_EN4   = 16'hF014;
  localparam logic [15:0] IRU_IDX_EN5   = 16'hF015;
  localparam logic [15:0] IRU_IDX_EN6   = 16'hF016;
  localparam logic [15:0] IRU_IDX_EN7   = 16'hF017;
  localparam logic [15:0] IRU_IDX_RQ0   = 16'hF018;
  localparam logic [15:0] IRU_IDX_RQ1   = 16'hF019;
  localparam logic [15:0] IRU_IDX_RQ2   = 16'hF01A;
  localparam logic [15:0] IRU_IDX_RQ3   = 16'hF01B;
  localparam logic [15:0] IRU_IDX_RQ4   = 16'hF01C;
  localparam logic [15:0] IRU_IDX_RQ5   = 16'hF01D;
  localparam logic [15:0] IRU_IDX_RQ6   = 16'hF01E;
  localparam logic [15:0] IRU_IDX_RQ7   = 16'hF01F;
  localparam logic [15:0] IRU_IDX_MEN   = 16'hF020;
  localparam logic [15:0] IRU_IDX_SWINT = 16'hF021;
  localparam logic [15:0] IRU_IDX_EDGL = 16'hF024;
  localparam logic [15:0] IRU_IDX_EDGH = 16'hF025;
  localparam logic [15:0] IRU_IDX_SAMP = 16'hF026;

  localparam int unsigned IRU_NUM_EN  = 7;
  localparam int unsigned IRU_NUM_REQ = 8;
  localparam logic [7:0]  IRU_RESET_VAL = 8'h00;

  // Implemented bits per enable register, then per request register
  localparam logic [6:0][7:0] IRU_EN_MASK  = {8'h09, 8'hA0, 8'h30, 8'h01, 8'h33, 8'hC7, 8'hFF};
  localparam logic [7:0][7:0] IRU_REQ_MASK = {IRU_EN_MASK, 8'h03};

  // -----------------------------------------------------------------
  // Sample tick timing
  // -----------------------------------------------------------------
  localparam int unsigned IRU_CLK_HZ        = 50_000_000;
  localparam int unsigned IRU_SAMPLE_HZ     = 16_000;
  localparam int unsigned IRU_SAMPLE_CYCLES = IRU_CLK_HZ / IRU_SAMPLE_HZ;

  // Peripheral event strobes, one cycle each
  typedef struct packed {
    logic wdt;
    logic nmi;
    logic serial0;
    logic serial1;
    logic adc;
    logic i2c_slave;
    logic i2c_master;
    logic timer0;
    logic timer1;
    logic voice0;
    logic spk_short;
    logic uart0;
    logic timer2;
    logic timer3;
    logic tb_128hz;
    logic tb_32hz;
    logic tb_16hz;
    logic tb_2hz;
  } iru_evt_s;

  typedef struct packed {
    logic [6:0][7:0] en;
    logic [7:0][7:0] req;
    logic [7:0]      edge_lo;
    logic [7:0]      edge_hi;
    logic [7:0]      samp;
    logic [7:0]      pin_prev;
    logic [7:0]      pin_smp;
    logic            men;
    logic [11:0]     div;
    logic            tick;
    logic [31:0]     prdata;
    logic            pready;
    logic            pslverr;
    logic            irq;
    logic            nmi;
    logic [5:0]      id;
    logic            sw_int;
    logic [5:0]      sw_vec;
  } iru_state_s;

endpackage

//--- iru_top.sv
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
module iru_top (
  input  wire logic             clock_i,
  input  wire logic             reset_n_i,
  input  wire logic             psel_i,
  input  wire logic             penable_i,
  input  wire logic             pwrite_i,
  input  wire logic [31:0]      paddr_i,
  input  wire logic [31:0]      pwdata_i,
  input  wire logic [3:0]       pstrb_i,
  output logic      [31:0]      prdata_o,
  output logic                  pready_o,
  output logic                  pslverr_o,
  input  wire logic [7:0]       pins_i,
  input  wire logic             stop_mode_i,
  input  wire iru_pkg::iru_evt_s events_i,
  input  wire logic             cpu_ack_i,
  input  wire logic [5:0]       cpu_ack_id_i,
  output logic                  irq_o,
  output logic                  nmi_o,
  output logic      [5:0]       int_id_o,
  output logic                  master_int_enable_o,
  output logic                  software_interrupt_o,
  output logic      [5:0]       sw_vector_o
);
  import iru_pkg::*;

  iru_state_s s_q;
  iru_state_s s_d;

  // -----------------------------------------------------------------
  // Pin edge detection
  // -----------------------------------------------------------------
  logic [7:0] pin_lvl;
  logic [7:0] pin_evt;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pin
      // Sampled pins only see level changes at tick rate
      assign pin_lvl[gi] = s_q.samp[gi] ? s_q.pin_smp[gi] : pins_i[gi]; // R5 R15
      assign pin_evt[gi] = (s_q.edge_hi[gi] & pin_lvl[gi] & ~s_q.pin_prev[gi]) |
                           (s_q.edge_lo[gi] & ~pin_lvl[gi] & s_q.pin_prev[gi]); // R6 R14
    end
  endgenerate

  // -----------------------------------------------------------------
  // Event and address decode
  // -----------------------------------------------------------------
  logic [7:0][7:0] evt;
  logic [15:0]     idx;
  logic [15:0]     en_off;
  logic [15:0]     rq_off;
  logic            addr_ok;
  logic            hit_en;
  logic            hit_rq;
  logic            hit_misc;
  logic            setup;
  logic            wr;
  logic [7:0]      wdat;

  always_comb begin
    evt[0] = {6'h00, events_i.nmi, events_i.wdt}; // R1 R2
    evt[1] = pin_evt; // R6
    evt[2] = {events_i.i2c_master, events_i.i2c_slave, 3'h0, events_i.adc,
              events_i.serial1, events_i.serial0};
    evt[3] = {2'h0, events_i.spk_short, events_i.voice0, 2'h0, events_i.timer1, events_i.timer0};
    evt[4] = {7'h00, events_i.uart0};
    evt[5] = {2'h0, events_i.timer3, events_i.timer2, 4'h0};
    evt[6] = {events_i.tb_32hz, 1'h0, events_i.tb_128hz, 5'h00};
    evt[7] = {4'h0, events_i.tb_2hz, 2'h0, events_i.tb_16hz};
  end

  assign idx      = paddr_i[17:2];
  assign addr_ok  = (paddr_i[31:18] == 14'h0000) && (paddr_i[1:0] == 2'h0);
  assign en_off   = idx - IRU_IDX_EN1;
  assign rq_off   = idx - IRU_IDX_RQ0;
  assign hit_en   = addr_ok && (idx >= IRU_IDX_EN1) && (idx <= IRU_IDX_EN7);
  assign hit_rq   = addr_ok && (idx >= IRU_IDX_RQ0) && (idx <= IRU_IDX_RQ7);
  assign hit_misc = addr_ok && ((idx == IRU_IDX_MEN) || (idx == IRU_IDX_SWINT) ||
                    (idx == IRU_IDX_EDGL) || (idx == IRU_IDX_EDGH) || (idx == IRU_IDX_SAMP));
  assign setup    = psel_i && !penable_i;
  // Writes land only at the completing access edge, and only with lane 0 strobed
  assign wr       = psel_i && penable_i && s_q.pready && pwrite_i && pstrb_i[0] && !s_q.pslverr;
  assign wdat     = pwdata_i[7:0];

  // -----------------------------------------------------------------
  // Next-state logic
  // -----------------------------------------------------------------
  always_comb begin
    logic [7:0] rd;
    logic [7:0] clr;
    logic       any_mask;
    rd       = 8'h00;
    clr      = 8'h00;
    any_mask = 1'b0;
    s_d      = s_q;

    // Sample tick divider; frozen in stop mode as the slow clock halts
    s_d.tick = 1'b0;
    if (!stop_mode_i) begin // R15
      if (s_q.div == 12'(IRU_SAMPLE_CYCLES - 1)) begin
        s_d.div  = 12'h000;
        s_d.tick = 1'b1;
      end else begin
        s_d.div = s_q.div + 12'h001;
      end
    end
    for (int n = 0; n < 8; n++) begin
      if (s_q.tick) begin
        s_d.pin_smp[n] = pins_i[n]; // R15
      end
    end
    s_d.pin_prev = pin_lvl;

    // Enable registers: unused bits forced to zero
    for (int r = 0; r < IRU_NUM_EN; r++) begin
      if (wr && hit_en && (en_off == 16'(r))) begin
        s_d.en[r] = wdat & IRU_EN_MASK[r]; // R8 R9 R10 R11 R12 R18
      end
    end

    // Request flags: hardware set wins over acceptance and software write
    for (int r = 0; r < IRU_NUM_REQ; r++) begin
      clr = 8'h00;
      if (cpu_ack_i && (cpu_ack_id_i[5:3] == 3'(r))) begin
        clr[cpu_ack_id_i[2:0]] = 1'b1;
      end
      if (wr && hit_rq && (rq_off == 16'(r))) begin
        s_d.req[r] = (wdat | evt[r]) & IRU_REQ_MASK[r]; // R17
      end else begin
        s_d.req[r] = ((s_q.req[r] & ~clr) | evt[r]) & IRU_REQ_MASK[r]; // R16 R17
      end
    end

    // Master enable: acceptance of a maskable request beats a software set
    if (cpu_ack_i && (cpu_ack_id_i[5:3] != 3'h0)) begin
      s_d.men = 1'b0; // R7
    end else if (wr && (idx == IRU_IDX_MEN)) begin
      s_d.men = wdat[0];
    end

    s_d.sw_int = 1'b0;
    if (wr && (idx == IRU_IDX_SWINT)) begin
      s_d.sw_int = 1'b1; // R4
      s_d.sw_vec = wdat[5:0];
    end
    if (wr && (idx == IRU_IDX_EDGL)) begin
      s_d.edge_lo = wdat; // R5 R14
    end
    if (wr && (idx == IRU_IDX_EDGH)) begin
      s_d.edge_hi = wdat; // R14
    end
    if (wr && (idx == IRU_IDX_SAMP)) begin
      s_d.samp = wdat; // R5
    end

    // Lowest pending id wins among NMI flags and enabled maskable flags; scan high to low so the last match stays
    s_d.irq = 1'b0;
    s_d.nmi = |s_q.req[0]; // R2
    s_d.id  = 6'h00;
    for (int r = IRU_NUM_REQ - 1; r >= 0; r--) begin
      for (int b = 7; b >= 0; b--) begin
        if (r == 0) begin
          if (s_q.req[0][b]) begin
            s_d.id = 6'((r * 8) + b);
          end
        end else if (s_q.req[r][b] && s_q.en[r-1][b] && s_q.men) begin // R3 R16
          any_mask = 1'b1;
          if (!s_d.nmi) begin
            s_d.id = 6'((r * 8) + b);
          end
        end
      end
    end
    s_d.irq = any_mask;

    // APB: data and status are captured in setup, so the access phase has no wait
    if (hit_en) begin
      rd = s_q.en[en_off[2:0]];
    end else if (hit_rq) begin
      rd = s_q.req[rq_off[2:0]]; // R13
    end else if (idx == IRU_IDX_MEN) begin
      rd = {7'h00, s_q.men};
    end else if (idx == IRU_IDX_SWINT) begin
      rd = {2'h0, s_q.sw_vec};
    end else if (idx == IRU_IDX_EDGL) begin
      rd = s_q.edge_lo;
    end else if (idx == IRU_IDX_EDGH) begin
      rd = s_q.edge_hi;
    end else if (idx == IRU_IDX_SAMP) begin
      rd = s_q.samp;
    end
    s_d.pready  = setup;
    s_d.pslverr = setup && !(hit_en || hit_rq || hit_misc);
    if (setup) begin
      s_d.prdata = (addr_ok && !pwrite_i) ? {24'h000000, rd} : 32'h00000000;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      s_q <= '0; // R13
    end else begin
      s_q <= s_d;
    end
  end

  // -----------------------------------------------------------------
  // Outputs
  // -----------------------------------------------------------------
  assign prdata_o             = s_q.prdata;
  assign pready_o             = s_q.pready;
  assign pslverr_o            = s_q.pslverr;
  assign irq_o                = s_q.irq;
  assign nmi_o                = s_q.nmi;
  assign int_id_o             = s_q.id;
  assign master_int_enable_o  = s_q.men;
  assign software_interrupt_o = s_q.sw_int;
  assign sw_vector_o          = s_q.sw_vec;

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  logic [63:0] req_flat;
  logic [63:0] evt_flat;
  logic [7:0]  mask_pend;
  assign req_flat = s_q.req;
  assign evt_flat = evt;
  always_comb begin
    mask_pend = 8'h00;
    for (int r = 1; r < IRU_NUM_REQ; r++) begin
      mask_pend[r] = |(s_q.req[r] & s_q.en[r-1]);
    end
  end

  mask_gate_a: assert property (@(posedge clock_i) disable iff (!reset_n_i) // R16
    irq_o == $past(s_q.men && (|mask_pend), 1)) else $error("irq not gated by enables");

  nmi_free_a: assert property (@(posedge clock_i) disable iff (!reset_n_i) // R2
    (|s_q.req[0]) && !s_q.men |=> nmi_o) else $error("nmi blocked by master enable");

  ack_mie_a: assert property (@(posedge clock_i) disable iff (!reset_n_i) // R7
    cpu_ack_i && (cpu_ack_id_i[5:3] != 3'h0) |=> !master_int_enable_o) else $error("master enable kept");

  ack_keeps_en_a: assert property (@(posedge clock_i) disable iff (!reset_n_i) // R7
    cpu_ack_i && !wr |=> $stable(s_q.en)) else $error("enable changed on accept");

  pin_edge_a: assert property (@(posedge clock_i) disable iff (!reset_n_i) // R6
    (pin_evt != 8'h00) |=> ((s_q.req[1] & $past(pin_evt)) == $past(pin_evt))) else $error("pin edge lost");

  ack_clear_a: assert property (@(posedge clock_i) disable iff (!reset_n_i) // R17
    cpu_ack_i && !wr |=> req_flat[$past(cpu_ack_id_i)] == $past(evt_flat[cpu_ack_id_i]))
    else $error("accepted flag not cleared");

  unused_bits_a: assert property (@(posedge clock_i) disable iff (!reset_n_i) // R18
    (s_q.en[1] & ~IRU_EN_MASK[1]) == 8'h00 && (s_q.en[3] & ~IRU_EN_MASK[3]) == 8'h00)
    else $error("unused enable bit set");

  stop_tick_a: assert property (@(posedge clock_i) disable iff (!reset_n_i) // R15
    stop_mode_i ##1 stop_mode_i ##1 stop_mode_i |-> !s_q.tick && $stable(s_q.pin_smp))
    else $error("sampling in stop");

  swi_pulse_a: assert property (@(posedge clock_i) disable iff (!reset_n_i) // R4
    software_interrupt_o |-> $past(wr) && !$past(software_interrupt_o) ##1 !software_interrupt_o)
    else $error("software interrupt not a single pulse");

  apb_ready_a: assert property (@(posedge clock_i) disable iff (!reset_n_i) // R13
    setup |=> pready_o) else $error("no ready after setup");

endmodule

//--- iru_top_bench.sv
`timescale 1ns/1ps
module iru_top_bench;
  import iru_pkg::*;
  logic clock_i = 1'b0, reset_n_i = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
  logic pready, pslverr, stop_mode = 1'b0, cpu_ack, irq, nmi, men, sw_int, accept_en = 1'b0;
  logic [7:0] pins = 8'h00, rd;
  logic [5:0] ack_id, int_id, sw_vec, last_id;
  logic [3:0] delay = 4'h0;
  iru_evt_s evt = '0;
  int errors = 0, samples_checked = 0;
  always #10 clock_i = ~clock_i;
  iru_top dut_u (.clock_i(clock_i), .reset_n_i(reset_n_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hF), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .pins_i(pins), .stop_mode_i(stop_mode), .events_i(evt),
    .cpu_ack_i(cpu_ack), .cpu_ack_id_i(ack_id), .irq_o(irq), .nmi_o(nmi), .int_id_o(int_id),
    .master_int_enable_o(men), .software_interrupt_o(sw_int), .sw_vector_o(sw_vec));
  iru_cpu_model cpu_u (.clock_i(clock_i), .reset_n_i(reset_n_i), .accept_en_i(accept_en),
    .delay_i(delay), .irq_i(irq), .nmi_i(nmi), .int_id_i(int_id), .cpu_ack_o(cpu_ack),
    .cpu_ack_id_o(ack_id), .last_id_o(last_id));
  // ---------------------------------------------
  // Shared helpers
  // ---------------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Bench samples at the edge, before the design's updates land
  task apb(input logic w, input logic [15:0] idx, input logic [7:0] wd);
    @(posedge clock_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {14'h0, idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge clock_i);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never gets an answer
    do begin
      @(posedge clock_i);
    end while (pready !== 1'b1);
    rd = prdata[7:0];
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rchk(input logic [15:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(rd, exp);
    chk(prdata[31:8], 24'h000000);
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  task pulse(input iru_evt_s e);
    @(posedge clock_i) evt <= e;
    @(posedge clock_i) evt <= '0;
  endtask
  task accept(input logic [3:0] d, input logic [5:0] id);
    delay <= d;
    accept_en <= 1'b1;
    cyc(20);
    accept_en <= 1'b0;
    chk(last_id, id);
  endtask
  // ---------------------------------------------
  // Scenarios
  // ---------------------------------------------
  task t_reset;
    logic [7:0] mask [7] = '{8'hFF, 8'hC7, 8'h33, 8'h01, 8'h30, 8'hA0, 8'h09};
    for (int i = 0; i < 15; i++) rchk(IRU_IDX_EN1 + 16'(i), 8'h00);
    apb(1'b0, 16'hF022, 8'h00);
    chk(pslverr, 1'b1);
    for (int i = 0; i < 7; i++) begin
      apb(1'b1, IRU_IDX_EN1 + 16'(i), 8'hFF);
      rchk(IRU_IDX_EN1 + 16'(i), mask[i]);
      apb(1'b1, IRU_IDX_EN1 + 16'(i), 8'h00);
    end
  endtask
  task t_mask;
    iru_evt_s e = '0;
    e.serial0 = 1'b1;
    pulse(e);
    rchk(IRU_IDX_RQ2, 8'h01);
    apb(1'b1, IRU_IDX_EN2, 8'h01);
    cyc(3);
    chk(irq, 1'b0);
    apb(1'b1, IRU_IDX_MEN, 8'h01);
    cyc(3);
    chk(irq, 1'b1);
    accept(4'h3, 6'd16);
    rchk(IRU_IDX_RQ2, 8'h00);
    chk(men, 1'b0);
    rchk(IRU_IDX_EN2, 8'h01);
    chk(irq, 1'b0);
  endtask
  task t_nmi;
    iru_evt_s e = '0;
    e.nmi = 1'b1;
    pulse(e);
    cyc(3);
    chk(nmi, 1'b1);
    accept(4'h0, 6'd1);
    rchk(IRU_IDX_RQ0, 8'h00);
  endtask
  task t_pins;
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, IRU_IDX_EDGL, m[0] ? 8'h08 : 8'h00);
      apb(1'b1, IRU_IDX_EDGH, m[1] ? 8'h08 : 8'h00);
      apb(1'b1, IRU_IDX_RQ1, 8'h00);
      @(posedge clock_i) pins <= 8'h08;
      cyc(3);
      rchk(IRU_IDX_RQ1, m[1] ? 8'h08 : 8'h00);
      apb(1'b1, IRU_IDX_RQ1, 8'h00);
      @(posedge clock_i) pins <= 8'h00;
      cyc(3);
      rchk(IRU_IDX_RQ1, m[0] ? 8'h08 : 8'h00);
    end
    apb(1'b1, IRU_IDX_RQ1, 8'h00);
  endtask
  task t_sample;
    apb(1'b1, IRU_IDX_EDGL, 8'h00);
    apb(1'b1, IRU_IDX_EDGH, 8'h01);
    apb(1'b1, IRU_IDX_SAMP, 8'h01);
    stop_mode <= 1'b1;
    @(posedge clock_i) pins <= 8'h01;
    cyc(3300);
    rchk(IRU_IDX_RQ1, 8'h00);
    stop_mode <= 1'b0;
    cyc(3300);
    rchk(IRU_IDX_RQ1, 8'h01);
  endtask
  task t_swi;
    logic seen = 1'b0;
    apb(1'b1, IRU_IDX_EN5, 8'h10);
    apb(1'b1, IRU_IDX_MEN, 8'h01);
    apb(1'b1, IRU_IDX_RQ5, 8'h10);
    cyc(3);
    chk(irq, 1'b1);
    accept(4'h1, 6'd44);
    rchk(IRU_IDX_RQ5, 8'h00);
    apb(1'b1, IRU_IDX_SWINT, 8'h3F);
    repeat (4) begin
      @(posedge clock_i);
      if (sw_int === 1'b1) seen = 1'b1;
    end
    chk(seen, 1'b1);
    chk(sw_vec, 6'h3F);
  endtask
  task test_done;
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    cyc(8);
    reset_n_i <= 1'b1;
    t_reset;
    t_mask;
    t_nmi;
    t_pins;
    t_sample;
    t_swi;
    test_done;
  end
  initial begin
    cyc(20000);
    errors++;
    test_done;
  end
endmodule
